// *** phy_id_and_an_advert_regs.sv ***
// Serial management slave in front of the identifier and advertisement bank.
// Assumes management clock, data and straps are asynchronous pins.
//
// Overview of operation
// - Two registers together give a 32-bit id: unique id, model, revision.
// - First id register returns unique-id bits 3 to 18 in bits 15:0.
// - Second id register returns unique-id bits 19 to 24 in bits 15:10.
// - Second id register carries six-bit model number in bits 9:4.
// - Second id register carries four-bit revision in bits 3:0.
// - Advertisement register holds local abilities sent to the link partner.
// - Bit 15 is writable next-page request, reset zero.
// - Bit 14 is reserved: writes ignored, reads zero.
// - Bit 13 is writable remote-fault advertisement, reset zero.
// - Bit 12 is reserved, reads zero; software writes zero there.
// - Bit 11 is writable asymmetric pause, reset zero; outcome reported elsewhere.
// - Bit 10 is writable symmetric pause, reset zero.
// - Bit 9, four-pair ability, is read-only zero.
// - Bits 8 to 5 are writable abilities with strap reset values.
// - Bits 4:0 are a writable selector resetting to 00001.
// - All registers are reached over the serial management interface.
`timescale 1ns/100ps
module phy_id_and_an_advert_regs (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        mdc_i,
   input  wire logic        mdio_i,
   input  wire logic [4:0]  phy_address_i,
   input  wire logic [3:0]  strap_ability_i,
   output logic             mdio_o,
   output logic             mdio_oe_o,
   output logic [15:0]      advert_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State of the frame engine

   typedef struct packed {
      logic [1:0]              mdc_sync;
      logic                    mdc_prev;
      logic [1:0]              mdio_sync;
      logic [1:0][4:0]         addr_sync;
      logic [1:0][3:0]         strap_sync;
      logic [1:0]              settle_cnt;
      logic                    settled;
      logic                    strap_load;
      logic [4:0]              phy_addr;
      mgmt_pkg::frame_state_t  state;
      logic [5:0]              bit_cnt;
      logic [15:0]             shift;
      logic                    is_read;
      logic [4:0]              reg_addr;
      logic                    mdio_out;
      logic                    mdio_oe;
      mgmt_pkg::mgmt_req_t     req;
   } engine_state_t;

   engine_state_t s;
   engine_state_t next_s;

   logic [15:0] rd_data;
   logic        mdc_rise;
   logic        bit_in;
   logic [12:0] header;

   // Edge of the synchronised management clock and the sampled data bit
   assign mdc_rise = s.mdc_sync[1] & ~s.mdc_prev;
   assign bit_in   = s.mdio_sync[1];
   // Header bits: second start bit, opcode, phy address, register index
   assign header   = {s.shift[11:0], bit_in};

   ////////////////////////////////////////////////////////////////////////////
   // Register bank

   adv_reg_bank bank (
      .ref_clk_i       (ref_clk_i),
      .rst_b_i         (rst_b_i),
      .req_i           (s.req),
      .strap_load_i    (s.strap_load),
      .strap_ability_i (s.strap_sync[1]),
      .rd_data_o       (rd_data),
      .advert_o        (advert_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_s            = s;
      next_s.req.rd     = 1'b0;
      next_s.req.wr     = 1'b0;
      next_s.strap_load = 1'b0;

      // Two-stage synchronisers for every pin
      next_s.mdc_sync[0]   = mdc_i;
      next_s.mdc_sync[1]   = s.mdc_sync[0];
      next_s.mdc_prev      = s.mdc_sync[1];
      next_s.mdio_sync[0]  = mdio_i;
      next_s.mdio_sync[1]  = s.mdio_sync[0];
      next_s.addr_sync[0]  = phy_address_i;
      next_s.addr_sync[1]  = s.addr_sync[0];
      next_s.strap_sync[0] = strap_ability_i;
      next_s.strap_sync[1] = s.strap_sync[0];

      // Catch straps once the synchronisers hold pin values
      if (!s.settled) begin
         if (s.settle_cnt == mgmt_pkg::SETTLE_LAST) begin
            next_s.settled    = 1'b1;
            next_s.strap_load = 1'b1;
            next_s.phy_addr   = s.addr_sync[1];
         end else begin
            next_s.settle_cnt = s.settle_cnt + 2'h1;
         end
      end

      // Frame engine advances on each management clock rise
      if (s.settled && mdc_rise) begin
         case (s.state)
            mgmt_pkg::ST_IDLE: begin
               // Count preamble ones, a zero after a full preamble starts
               if (bit_in) begin
                  if (s.bit_cnt != mgmt_pkg::PREAMBLE_LEN) begin
                     next_s.bit_cnt = s.bit_cnt + 6'h01;
                  end
               end else if (s.bit_cnt == mgmt_pkg::PREAMBLE_LEN) begin
                  next_s.state   = mgmt_pkg::ST_HEADER;
                  next_s.bit_cnt = 6'h00;
                  next_s.shift   = 16'h0000;
               end else begin
                  next_s.bit_cnt = 6'h00;
               end
            end

            mgmt_pkg::ST_HEADER: begin
               next_s.shift   = {s.shift[14:0], bit_in};
               next_s.bit_cnt = s.bit_cnt + 6'h01;
               if (s.bit_cnt == mgmt_pkg::HEADER_LAST) begin
                  next_s.bit_cnt  = 6'h00;
                  next_s.reg_addr = header[4:0];
                  next_s.state    = mgmt_pkg::ST_IDLE;
                  // Only a well-formed frame for this address is served
                  if (header[12] && header[9:5] == s.phy_addr) begin
                     if (header[11:10] == mgmt_pkg::OP_READ) begin
                        next_s.state    = mgmt_pkg::ST_TURN;
                        next_s.is_read  = 1'b1;
                        next_s.req.rd   = 1'b1;
                        next_s.req.addr = header[4:0];
                     end else if (header[11:10] == mgmt_pkg::OP_WRITE) begin
                        next_s.state    = mgmt_pkg::ST_TURN;
                        next_s.is_read  = 1'b0;
                     end
                  end
               end
            end

            mgmt_pkg::ST_TURN: begin
               if (s.bit_cnt == 6'h00) begin
                  // Second turnaround bit: slave drives zero on reads
                  next_s.bit_cnt = 6'h01;
                  if (s.is_read) begin
                     next_s.mdio_oe  = 1'b1;
                     next_s.mdio_out = 1'b0;
                  end
               end else begin
                  next_s.bit_cnt = 6'h00;
                  if (s.is_read) begin
                     next_s.state    = mgmt_pkg::ST_READ;
                     next_s.mdio_out = rd_data[15];
                     next_s.shift    = {rd_data[14:0], 1'b0};
                  end else begin
                     next_s.state = mgmt_pkg::ST_WRITE;
                  end
               end
            end

            mgmt_pkg::ST_READ: begin
               // Shift the read word out, most significant bit first
               next_s.bit_cnt = s.bit_cnt + 6'h01;
               if (s.bit_cnt == mgmt_pkg::DATA_LAST) begin
                  next_s.state    = mgmt_pkg::ST_IDLE;
                  next_s.bit_cnt  = 6'h00;
                  next_s.mdio_oe  = 1'b0;
                  next_s.mdio_out = 1'b0;
               end else begin
                  next_s.mdio_out = s.shift[15];
                  next_s.shift    = {s.shift[14:0], 1'b0};
               end
            end

            mgmt_pkg::ST_WRITE: begin
               // Collect the write word, then hand it to the bank
               next_s.shift   = {s.shift[14:0], bit_in};
               next_s.bit_cnt = s.bit_cnt + 6'h01;
               if (s.bit_cnt == mgmt_pkg::DATA_LAST) begin
                  next_s.state    = mgmt_pkg::ST_IDLE;
                  next_s.bit_cnt  = 6'h00;
                  next_s.req.wr   = 1'b1;
                  next_s.req.addr = s.reg_addr;
                  next_s.req.data = {s.shift[14:0], bit_in};
               end
            end

            default: begin
               next_s.state   = mgmt_pkg::ST_IDLE;
               next_s.bit_cnt = 6'h00;
               next_s.mdio_oe = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s.mdc_sync   <= 2'h0;
         s.mdc_prev   <= 1'b0;
         s.mdio_sync  <= 2'h0;
         s.addr_sync  <= 10'h000;
         s.strap_sync <= 8'h00;
         s.settle_cnt <= 2'h0;
         s.settled    <= 1'b0;
         s.strap_load <= 1'b0;
         s.phy_addr   <= 5'h00;
         s.state      <= mgmt_pkg::ST_IDLE;
         s.bit_cnt    <= 6'h00;
         s.shift      <= 16'h0000;
         s.is_read    <= 1'b0;
         s.reg_addr   <= 5'h00;
         s.mdio_out   <= 1'b0;
         s.mdio_oe    <= 1'b0;
         s.req        <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Pin drivers straight from the state register
   assign mdio_o    = s.mdio_out;
   assign mdio_oe_o = s.mdio_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the frame engine

   read_drive_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s.state == mgmt_pkg::ST_READ |-> mdio_oe_o)
      else $error("read data phase not driven");

   turn_zero_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(mdio_oe_o) |-> !mdio_o && s.state == mgmt_pkg::ST_TURN && s.is_read)
      else $error("turnaround not driven low");

   read_issue_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s.req.rd |-> s.state == mgmt_pkg::ST_TURN && s.is_read && !mdio_oe_o)
      else $error("read request outside turnaround");

   write_issue_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s.req.wr |-> s.state == mgmt_pkg::ST_IDLE && !mdio_oe_o
                   && $past(s.state) == mgmt_pkg::ST_WRITE)
      else $error("write request not at end of write frame");

   first_bit_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s.state == mgmt_pkg::ST_TURN && s.is_read && mdc_rise && s.bit_cnt == 6'h01
      |=> mdio_o == rd_data[15] && s.state == mgmt_pkg::ST_READ)
      else $error("first read bit not the word msb");

   strap_once_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      s.strap_load |=> s.settled && !s.strap_load)
      else $error("strap load repeated");

endmodule

// *** mgmt_pkg.sv ***
// Constants, types and field layout for the management register slice.
// Assumes one 25 MHz clock and an active-low asynchronous reset.
package mgmt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices on the serial management interface
   localparam logic [4:0]  REG_ID_HIGH     = 5'h02;
   localparam logic [4:0]  REG_ID_LOW      = 5'h03;
   localparam logic [4:0]  REG_ADVERT      = 5'h04;

   ////////////////////////////////////////////////////////////////////////////
   // Identifier contents, bit 1 of the unique id is its first bit
   localparam logic [1:24] UNIQUE_ID       = 24'h5a3c96; // Arbitrary value
   localparam logic [5:0]  MODEL_NUMBER    = 6'h2a;      // Arbitrary value
   localparam logic [3:0]  MODEL_REVISION  = 4'h3;       // Arbitrary value
   localparam logic [15:0] ID_HIGH_VALUE   = UNIQUE_ID[3:18];
   localparam logic [15:0] ID_LOW_VALUE    = {UNIQUE_ID[19:24], MODEL_NUMBER,
                                              MODEL_REVISION};

   ////////////////////////////////////////////////////////////////////////////
   // Advertisement field positions, masks and reset value
   localparam int          ADV_NEXT_PAGE   = 15;
   localparam int          ADV_RSVD_HI     = 14;
   localparam int          ADV_REMOTE_FLT  = 13;
   localparam int          ADV_RSVD_LO     = 12;
   localparam int          ADV_ASYM_PAUSE  = 11;
   localparam int          ADV_SYM_PAUSE   = 10;
   localparam int          ADV_FOUR_PAIR   = 9;
   localparam int          ADV_STRAP_LSB   = 5;
   localparam logic [15:0] ADV_WRITE_MASK  = 16'hadff;
   localparam logic [15:0] ADV_RESET       = 16'h0001;

   ////////////////////////////////////////////////////////////////////////////
   // Management frame layout and start-up timing
   localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
   localparam logic [5:0]  HEADER_LAST     = 6'h0c;
   localparam logic [5:0]  DATA_LAST       = 6'h0f;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [1:0]  SETTLE_LAST     = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_HEADER = 5'h02,
      ST_TURN   = 5'h04,
      ST_READ   = 5'h08,
      ST_WRITE  = 5'h10
   } frame_state_t;

   // One register access toward the bank
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [4:0]  addr;
      logic [15:0] data;
   } mgmt_req_t;

   typedef struct packed {
      logic [15:0] advert;
      logic [15:0] rd_data;
   } bank_state_t;

endpackage

// *** adv_reg_bank.sv ***
// Identifier and advertisement registers with a registered read port.
// Assumes requests arrive as single-cycle pulses from the frame engine.
`timescale 1ns/100ps
module adv_reg_bank (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_b_i,
   input  wire mgmt_pkg::mgmt_req_t req_i,
   input  wire logic                strap_load_i,
   input  wire logic [3:0]          strap_ability_i,
   output logic [15:0]              rd_data_o,
   output logic [15:0]              advert_o
);

   mgmt_pkg::bank_state_t s;
   mgmt_pkg::bank_state_t next_s;

   // Read mux; unmapped indices return zero
   function automatic logic [15:0] reg_read(input logic [4:0]  addr,
                                            input logic [15:0] adv);
      logic [15:0] val;
      val = 16'h0000;
      if (addr == mgmt_pkg::REG_ID_HIGH) begin
         val = mgmt_pkg::ID_HIGH_VALUE;
      end else if (addr == mgmt_pkg::REG_ID_LOW) begin
         val = mgmt_pkg::ID_LOW_VALUE;
      end else if (addr == mgmt_pkg::REG_ADVERT) begin
         val = adv;
      end
      return val;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state: strap load, masked writes, read capture
   always_comb begin
      next_s = s;
      if (strap_load_i) begin
         next_s.advert[mgmt_pkg::ADV_STRAP_LSB +: 4] = strap_ability_i;
      end
      // Identifier writes fall through untouched
      if (req_i.wr && req_i.addr == mgmt_pkg::REG_ADVERT) begin
         next_s.advert = req_i.data & mgmt_pkg::ADV_WRITE_MASK;
      end
      if (req_i.rd) begin
         next_s.rd_data = reg_read(req_i.addr, s.advert);
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s.advert  <= mgmt_pkg::ADV_RESET;
         s.rd_data <= 16'h0000;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rd_data;
   assign advert_o  = s.advert;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   id_high_read_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == mgmt_pkg::REG_ID_HIGH
      |=> rd_data_o == mgmt_pkg::ID_HIGH_VALUE)
      else $error("identifier high read wrong");

   id_low_read_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == mgmt_pkg::REG_ID_LOW
      |=> rd_data_o[15:10] == mgmt_pkg::UNIQUE_ID[19:24]
          && rd_data_o[9:4] == mgmt_pkg::MODEL_NUMBER
          && rd_data_o[3:0] == mgmt_pkg::MODEL_REVISION)
      else $error("identifier low read wrong");

   advert_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_i.wr && req_i.addr == mgmt_pkg::REG_ADVERT && !strap_load_i
      |=> advert_o == ($past(req_i.data) & 16'hadff))
      else $error("advertisement write not stored");

   rsvd_zero_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == mgmt_pkg::REG_ADVERT
      |=> rd_data_o[14] == 1'b0 && rd_data_o[12] == 1'b0 && rd_data_o[9] == 1'b0)
      else $error("reserved advertisement bit reads one");

   rsvd_store_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      advert_o[mgmt_pkg::ADV_RSVD_HI] == 1'b0 && advert_o[mgmt_pkg::ADV_RSVD_LO] == 1'b0
      && advert_o[mgmt_pkg::ADV_FOUR_PAIR] == 1'b0)
      else $error("reserved advertisement bit stored");

   id_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_i.wr && req_i.addr != mgmt_pkg::REG_ADVERT && !strap_load_i
      |=> $stable(advert_o))
      else $error("write elsewhere changed advertisement");

   strap_load_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      strap_load_i && !req_i.wr |=> advert_o[8:5] == $past(strap_ability_i))
      else $error("strap abilities not loaded");

endmodule

// *** mdio_host_model.sv ***
// Station management controller model driving clause-22 frames.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/100ps
module mdio_host_model (
   input  wire logic ref_clk_i,
   input  wire logic mdio_i,
   input  wire logic slave_oe_i,
   output logic      mdc_o,
   output logic      mdio_o,
   output logic      mdio_oe_o
);
   logic saw_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Idle: clock still, pin released
   initial begin
      mdc_o     = 1'b0;
      mdio_o    = 1'b0;
      mdio_oe_o = 1'b0;
      saw_oe    = 1'b0;
   end

   // Notes whether the slave ever drove the pin in this frame
   always @(posedge ref_clk_i) begin
      if (slave_oe_i) saw_oe = 1'b1;
   end

   // One bit: data set while clock low, sampled as the clock rises
   task automatic put_bit(input logic drive, input logic b, output logic s);
      mdio_oe_o = drive;
      mdio_o    = b;
      repeat (6) @(negedge ref_clk_i);
      s     = mdio_i;
      mdc_o = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      mdc_o = 1'b0;
   endtask

   // Whole frame with full preamble; reads release the pin from turnaround on
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic ta_bit);
      logic [13:0] head;
      logic [17:0] tail;
      logic [17:0] got;
      logic        s;
      logic        rd;
      int          i;
      @(negedge ref_clk_i);
      saw_oe = 1'b0;
      rd     = (op == mgmt_pkg::OP_READ);
      head   = {2'b01, op, phy, idx};
      tail   = {2'b10, wdata};
      if (idx == mgmt_pkg::REG_ADVERT) tail[12] = 1'b0; // Software writes zero here
      for (i = 0; i < 32; i++) put_bit(1'b1, 1'b1, s);
      for (i = 13; i >= 0; i--) put_bit(1'b1, head[i], s);
      for (i = 17; i >= 0; i--) begin
         put_bit(!rd, tail[i], s);
         got[i] = s;
      end
      mdio_oe_o = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      ta_bit = got[16];
      rdata  = got[15:0];
   endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the identifier and advertisement registers.
// Assumes the host model in mdio_host_model.sv and the mgmt_pkg constants.
`timescale 1ns/100ps
module tb_top;
   logic        ref_clk;
   logic        rst_b;
   logic        mdc;
   logic        host_mdio;
   logic        host_oe;
   logic        dut_mdio;
   logic        dut_oe;
   logic        mdio_wire;
   logic [4:0]  phy_addr;
   logic [3:0]  strap;
   logic [15:0] advert;
   logic [15:0] rdata;
   logic [15:0] w;
   logic        ta;
   integer      seed;
   int          n_errors;
   int          cmp_count;
   int          cyc;
   int          i;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, shared wire with pull-up, design and host
   always #20 ref_clk = ~ref_clk;
   assign mdio_wire = dut_oe ? dut_mdio : (host_oe ? host_mdio : 1'b1);

   phy_id_and_an_advert_regs dut_u (
      .ref_clk_i       (ref_clk),
      .rst_b_i         (rst_b),
      .mdc_i           (mdc),
      .mdio_i          (mdio_wire),
      .phy_address_i   (phy_addr),
      .strap_ability_i (strap),
      .mdio_o          (dut_mdio),
      .mdio_oe_o       (dut_oe),
      .advert_o        (advert)
   );

   mdio_host_model host_u (
      .ref_clk_i  (ref_clk),
      .mdio_i     (mdio_wire),
      .slave_oe_i (dut_oe),
      .mdc_o      (mdc),
      .mdio_o     (host_mdio),
      .mdio_oe_o  (host_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Expected values
   function automatic logic [15:0] id_high_exp();
      logic [15:0] v;
      for (int k = 3; k <= 18; k++) v[18 - k] = mgmt_pkg::UNIQUE_ID[k];
      return v;
   endfunction

   function automatic logic [15:0] id_low_exp();
      logic [15:0] v;
      for (int k = 19; k <= 24; k++) v[34 - k] = mgmt_pkg::UNIQUE_ID[k];
      v[9:4] = mgmt_pkg::MODEL_NUMBER;
      v[3:0] = mgmt_pkg::MODEL_REVISION;
      return v;
   endfunction

   function automatic logic [15:0] adv_exp(input logic [15:0] d);
      return {d[15], 1'b0, d[13], 1'b0, d[11:10], 1'b0, d[8:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Compare, access and closing tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: value %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [4:0] phy, input logic [4:0] idx);
      host_u.frame(mgmt_pkg::OP_READ, phy, idx, 16'h0000, rdata, ta);
   endtask

   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      host_u.frame(mgmt_pkg::OP_WRITE, phy_addr, idx, d, rdata, ta);
   endtask

   task automatic do_reset();
      @(negedge ref_clk);
      rst_b = 1'b0;
      strap = 4'($random(seed));
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (10) @(negedge ref_clk);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      ref_clk   = 1'b0;
      rst_b     = 1'b0;
      seed      = 50;
      n_errors  = 0;
      cmp_count = 0;
      cyc       = 0;
      phy_addr  = 5'($random(seed));
      strap     = 4'h0;
      do_reset();
      check(advert, {7'h00, strap, 5'h01});
      rd(phy_addr, mgmt_pkg::REG_ID_HIGH);
      check(rdata, id_high_exp());
      check({15'h0000, ta}, 16'h0000);
      rd(phy_addr, mgmt_pkg::REG_ID_LOW);
      check(rdata, id_low_exp());
      rd(phy_addr, mgmt_pkg::REG_ADVERT);
      check(rdata, {7'h00, strap, 5'h01});
      $display("Test reset_values done");
      wr(mgmt_pkg::REG_ID_HIGH, ~id_high_exp());
      wr(mgmt_pkg::REG_ID_LOW, ~id_low_exp());
      rd(phy_addr, mgmt_pkg::REG_ID_HIGH);
      check(rdata, id_high_exp());
      rd(phy_addr, mgmt_pkg::REG_ID_LOW);
      check(rdata, id_low_exp());
      $display("Test id_read_only done");
      for (i = 0; i < 8; i++) begin
         w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
         w[12] = 1'b0;
         wr(mgmt_pkg::REG_ADVERT, w);
         check(advert, adv_exp(w));
         rd(phy_addr, mgmt_pkg::REG_ADVERT);
         check(rdata, adv_exp(w));
      end
      $display("Test advert_write done");
      rd(phy_addr ^ 5'h01, mgmt_pkg::REG_ID_HIGH);
      check({15'h0000, host_u.saw_oe}, 16'h0000);
      check(rdata, 16'hffff);
      rd(phy_addr, 5'h1f);
      check(rdata, 16'h0000);
      wr(5'h1f, 16'h8421);
      check(advert, adv_exp(w));
      host_u.frame(2'b11, phy_addr, mgmt_pkg::REG_ADVERT, 16'h0000, rdata, ta);
      check({15'h0000, host_u.saw_oe}, 16'h0000);
      host_u.frame(2'b00, phy_addr, mgmt_pkg::REG_ADVERT, 16'h8421, rdata, ta);
      check(advert, adv_exp(w));
      check({15'h0000, host_u.saw_oe}, 16'h0000);
      $display("Test refusals done");
      do_reset();
      check(advert, {7'h00, strap, 5'h01});
      rd(phy_addr, mgmt_pkg::REG_ADVERT);
      check(rdata, {7'h00, strap, 5'h01});
      $display("Test second_reset done");
      finish_test();
   end
endmodule
